// ### logic/agtc_pkg.sv
// Constants, field layout and lookup functions for the AGC time constant bank.
// Assumes a page-0 byte register port decoded upstream of this block.
// Overview of operation
// - Left decay select 0 uses legacy decay time; 1 uses this register's fields.
// - Left decay baseline codes give 50, 150, 250 or 350 ms.
// - Decay multiplier field D4-D2 scales baseline by two to the field value.
// - Decay time is capped by the ADC decimation ratio, 4 s up to 22.4 s.
// - Right attack select 0 uses legacy attack time; 1 uses this register's fields.
// - Right attack baseline codes give 7, 8, 10 or 11 ms.
// - Attack multiplier scales baseline by two to the field value, 1 to 128.
// - Left decay register sits at page 0 address 104.
package agtc_pkg;
    // Register addresses on page 0
    localparam logic [7:0] LEFT_DECAY_ADDR = 8'h68;
    localparam logic [7:0] RIGHT_ATTACK_ADDR = 8'h69;
    localparam logic [7:0] CFG_RESET = 8'h00;
    // Field positions
    localparam int SEL_BIT = 7;
    localparam int BASE_HI = 6;
    localparam int BASE_LO = 5;
    localparam int MULT_HI = 4;
    localparam int MULT_LO = 2;
    // Time results are whole milliseconds; 350 ms x 128 needs 16 bits
    localparam int TIME_W = 16;
    // Baseline decay and attack times in ms
    localparam logic [15:0] DECAY_BASE_0 = 16'h0032;
    localparam logic [15:0] DECAY_BASE_1 = 16'h0096;
    localparam logic [15:0] DECAY_BASE_2 = 16'h00fa;
    localparam logic [15:0] DECAY_BASE_3 = 16'h015e;
    localparam logic [15:0] ATTACK_BASE_0 = 16'h0007;
    localparam logic [15:0] ATTACK_BASE_1 = 16'h0008;
    localparam logic [15:0] ATTACK_BASE_2 = 16'h000a;
    localparam logic [15:0] ATTACK_BASE_3 = 16'h000b;
    // Decay ceilings in ms: 4, 5.6, 8, 9.6, 11.2, 16, 19.2 and 22.4 s
    localparam logic [15:0] LIM_4S0 = 16'h0fa0;
    localparam logic [15:0] LIM_5S6 = 16'h15e0;
    localparam logic [15:0] LIM_8S0 = 16'h1f40;
    localparam logic [15:0] LIM_9S6 = 16'h2580;
    localparam logic [15:0] LIM_11S2 = 16'h2bc0;
    localparam logic [15:0] LIM_16S0 = 16'h3e80;
    localparam logic [15:0] LIM_19S2 = 16'h4b00;
    localparam logic [15:0] LIM_22S4 = 16'h5780;
    // Decimation ratio is carried as twice the ratio: 4'h2 is 1, 4'hc is 6
    localparam int RATIO_W = 4;

    // Baseline decay time for a two-bit code
    function automatic logic [15:0] decay_base(input logic [1:0] code);
        case (code)
            2'h0: decay_base = DECAY_BASE_0;
            2'h1: decay_base = DECAY_BASE_1;
            2'h2: decay_base = DECAY_BASE_2;
            default: decay_base = DECAY_BASE_3;
        endcase
    endfunction : decay_base

    // Baseline attack time for a two-bit code
    function automatic logic [15:0] attack_base(input logic [1:0] code);
        case (code)
            2'h0: attack_base = ATTACK_BASE_0;
            2'h1: attack_base = ATTACK_BASE_1;
            2'h2: attack_base = ATTACK_BASE_2;
            default: attack_base = ATTACK_BASE_3;
        endcase
    endfunction : attack_base

    // Ceiling for a doubled ratio; unsupported ratios take the tightest cap
    function automatic logic [15:0] decay_limit(input logic [3:0] ratio_x2);
        case (ratio_x2)
            4'h3: decay_limit = LIM_5S6;
            4'h4: decay_limit = LIM_8S0;
            4'h5: decay_limit = LIM_9S6;
            4'h6, 4'h7: decay_limit = LIM_11S2;
            4'h8, 4'h9: decay_limit = LIM_16S0;
            4'ha: decay_limit = LIM_19S2;
            4'hb, 4'hc: decay_limit = LIM_22S4;
            default: decay_limit = LIM_4S0;
        endcase
    endfunction : decay_limit

    // Baseline shifted by the multiplier code; 350 ms x 128 still fits
    function automatic logic [15:0] scale(input logic [15:0] base, input logic [2:0] mult);
        scale = base << mult;
    endfunction : scale
endpackage : agtc_pkg

// ### logic/agtc_time_cfg.sv
// Left decay and right attack time constant registers with effective time outputs.
// Assumes a page-0 byte register port already decoded from the control bus,
// legacy times and the decimation ratio driven synchronously to clk.
`timescale 1ns/100ps
`default_nettype none
module agtc_time_cfg #(
    parameter int TIME_W = agtc_pkg::TIME_W
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Page-0 register port
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr_en,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_rd_en,
    output logic [7:0] reg_rdata_ff,
    // Legacy times from the older timing registers, in ms
    input wire logic [TIME_W-1:0] legacy_left_decay_ms,
    input wire logic [TIME_W-1:0] legacy_right_attack_ms,
    // ADC decimation ratio, doubled
    input wire logic [agtc_pkg::RATIO_W-1:0] adc_decimation_ratio,
    // Effective times to the gain stepper, in ms
    output logic [TIME_W-1:0] left_decay_ms_ff,
    output logic [TIME_W-1:0] right_attack_ms_ff,
    output logic left_decay_new_sel_ff,
    output logic right_attack_new_sel_ff
);
    // Narrower results would silently lose the 128x settings; wider ones buy nothing,
    // since every lookup and ceiling is a 16-bit value, so both are refused here
    if (TIME_W != agtc_pkg::TIME_W) begin : g_time_w_bad
        $error("agtc_time_cfg: TIME_W must be 16");
    end

    // Stored register bytes and the combinational time paths
    logic [7:0] left_decay_cfg_ff;
    logic [7:0] right_attack_cfg_ff;
    logic [TIME_W-1:0] nxt_left_decay_ms;
    logic [TIME_W-1:0] nxt_right_attack_ms;
    logic [TIME_W-1:0] left_new_ms;
    logic [TIME_W-1:0] left_raw_ms;
    logic [TIME_W-1:0] left_limit_ms;
    logic [TIME_W-1:0] right_new_ms;

    // Register writes; reserved bits are stored as written, software keeps them zero
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            left_decay_cfg_ff <= agtc_pkg::CFG_RESET;
            right_attack_cfg_ff <= agtc_pkg::CFG_RESET;
        end else if (reg_wr_en) begin
            if (reg_addr == agtc_pkg::LEFT_DECAY_ADDR) begin
                left_decay_cfg_ff <= reg_wdata;
            end else if (reg_addr == agtc_pkg::RIGHT_ATTACK_ADDR) begin
                right_attack_cfg_ff <= reg_wdata;
            end
        end
    end

    // Read data one cycle after the strobe; unmapped addresses read zero
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata_ff <= 8'h00;
        end else if (reg_rd_en) begin
            if (reg_addr == agtc_pkg::LEFT_DECAY_ADDR) begin
                reg_rdata_ff <= left_decay_cfg_ff;
            end else if (reg_addr == agtc_pkg::RIGHT_ATTACK_ADDR) begin
                reg_rdata_ff <= right_attack_cfg_ff;
            end else begin
                reg_rdata_ff <= 8'h00;
            end
        end
    end

    // Decay: baseline shifted by multiplier, legacy or new, then clamped
    always_comb begin
        left_new_ms = agtc_pkg::scale(
            agtc_pkg::decay_base(left_decay_cfg_ff[agtc_pkg::BASE_HI:agtc_pkg::BASE_LO]),
            left_decay_cfg_ff[agtc_pkg::MULT_HI:agtc_pkg::MULT_LO]);
        left_raw_ms = left_decay_cfg_ff[agtc_pkg::SEL_BIT] ? left_new_ms
                                                           : legacy_left_decay_ms;
        left_limit_ms = agtc_pkg::decay_limit(adc_decimation_ratio);
        // Clamp also covers legacy times, since the cap is a property of the filter rate
        nxt_left_decay_ms = (left_raw_ms > left_limit_ms) ? left_limit_ms : left_raw_ms;
    end

    // Attack: baseline shifted by multiplier, legacy or new
    always_comb begin
        right_new_ms = agtc_pkg::scale(
            agtc_pkg::attack_base(right_attack_cfg_ff[agtc_pkg::BASE_HI:agtc_pkg::BASE_LO]),
            right_attack_cfg_ff[agtc_pkg::MULT_HI:agtc_pkg::MULT_LO]);
        nxt_right_attack_ms = right_attack_cfg_ff[agtc_pkg::SEL_BIT] ? right_new_ms
                                                                     : legacy_right_attack_ms;
    end

    // Registered times so the gain stepper sees glitch-free values
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            left_decay_ms_ff <= '0;
            right_attack_ms_ff <= '0;
            left_decay_new_sel_ff <= 1'b0;
            right_attack_new_sel_ff <= 1'b0;
        end else begin
            left_decay_ms_ff <= nxt_left_decay_ms;
            right_attack_ms_ff <= nxt_right_attack_ms;
            left_decay_new_sel_ff <= left_decay_cfg_ff[agtc_pkg::SEL_BIT];
            right_attack_new_sel_ff <= right_attack_cfg_ff[agtc_pkg::SEL_BIT];
        end
    end

    // Checks. The base, multiplier and top-setting checks each state a concrete setting and its expected time in ms,
    // so a wrong table entry or shift is caught rather than mirrored. Reset
    // disables them, since outputs sit at zero until the first edge after it.
    sequence s_left_wr;
        reg_wr_en && reg_addr == agtc_pkg::LEFT_DECAY_ADDR;
    endsequence

    sequence s_right_wr;
        reg_wr_en && reg_addr == agtc_pkg::RIGHT_ATTACK_ADDR;
    endsequence

    // Two cycles with no write, so a just-written byte reaches the outputs
    sequence s_quiet2;
        !reg_wr_en [*2];
    endsequence

    AST_LEFT_WRITE_READBACK: assert property (
        @(posedge clk) disable iff (!rst_n)
        s_left_wr ##1 (!reg_wr_en && reg_rd_en && reg_addr == agtc_pkg::LEFT_DECAY_ADDR)
        |=> reg_rdata_ff == $past(reg_wdata, 2))
        else $error("Left decay register read back differs from write");

    AST_LEFT_LEGACY: assert property (
        @(posedge clk) disable iff (!rst_n)
        (!left_decay_cfg_ff[agtc_pkg::SEL_BIT]
         && legacy_left_decay_ms <= agtc_pkg::decay_limit(adc_decimation_ratio))
        |=> left_decay_ms_ff == $past(legacy_left_decay_ms) && !left_decay_new_sel_ff)
        else $error("Left decay does not follow legacy time");

    AST_LEFT_NEW_BASE: assert property (
        @(posedge clk) disable iff (!rst_n)
        (s_left_wr and (reg_wdata[7:2] == 6'h20) and adc_decimation_ratio == 4'h2)
        ##1 s_quiet2 |-> left_decay_ms_ff == 16'h0032)
        else $error("Left decay code 00 x1 is not 50 ms");

    AST_LEFT_MULT: assert property (
        @(posedge clk) disable iff (!rst_n)
        (s_left_wr and (reg_wdata[7:2] == 6'h3f) and adc_decimation_ratio == 4'hc)
        ##1 (s_quiet2 and (adc_decimation_ratio == 4'hc) [*2]) |-> left_decay_ms_ff == 16'h5780)
        else $error("Left decay 350 ms x128 not clamped to 22.4 s");

    AST_DECAY_CAP: assert property (
        @(posedge clk) disable iff (!rst_n)
        1'b1 |=> left_decay_ms_ff <= agtc_pkg::decay_limit($past(adc_decimation_ratio)))
        else $error("Left decay exceeds decimation ceiling");

    AST_RIGHT_LEGACY: assert property (
        @(posedge clk) disable iff (!rst_n)
        !right_attack_cfg_ff[agtc_pkg::SEL_BIT]
        |=> right_attack_ms_ff == $past(legacy_right_attack_ms) && !right_attack_new_sel_ff)
        else $error("Right attack does not follow legacy time");

    AST_RIGHT_BASE: assert property (
        @(posedge clk) disable iff (!rst_n)
        (s_right_wr and reg_wdata[7:2] == 6'h38) ##1 s_quiet2
        |-> right_attack_ms_ff == 16'h000b && right_attack_new_sel_ff)
        else $error("Right attack code 11 x1 is not 11 ms");

    AST_RIGHT_MULT: assert property (
        @(posedge clk) disable iff (!rst_n)
        (s_right_wr and reg_wdata[7:2] == 6'h27) ##1 s_quiet2
        |-> right_attack_ms_ff == 16'h0380)
        else $error("Right attack 7 ms x128 is not 896 ms");

    AST_UNMAPPED_READ_ZERO: assert property (
        @(posedge clk) disable iff (!rst_n)
        (reg_rd_en && reg_addr != agtc_pkg::LEFT_DECAY_ADDR
         && reg_addr != agtc_pkg::RIGHT_ATTACK_ADDR) |=> reg_rdata_ff == 8'h00)
        else $error("Unmapped read is not zero");

    // The two highest settings: the decay must be clamped, the attack must not be
    sequence s_left_top;
        left_decay_cfg_ff[agtc_pkg::SEL_BIT:agtc_pkg::MULT_LO] == 6'h3f;
    endsequence

    sequence s_right_top;
        right_attack_cfg_ff[agtc_pkg::SEL_BIT:agtc_pkg::MULT_LO] == 6'h3f;
    endsequence

    // 350 ms x128 is far past the 8 s ceiling of ratio 2
    AST_LEFT_CAP_BITES: assert property (
        @(posedge clk) disable iff (!rst_n)
        (s_left_top and adc_decimation_ratio == 4'h4) |=> left_decay_ms_ff == agtc_pkg::LIM_8S0)
        else $error("Left decay 350 ms x128 not clamped to 8 s");

    // Attack is never clamped, so 11 ms x128 comes through whole
    AST_RIGHT_NO_CAP: assert property (
        @(posedge clk) disable iff (!rst_n)
        s_right_top |=> right_attack_ms_ff == 16'h0580)
        else $error("Right attack 11 ms x128 is not 1408 ms");

    // Ratios outside the table fall back to the tightest ceiling
    AST_ODD_RATIO_CAP: assert property (
        @(posedge clk) disable iff (!rst_n)
        (adc_decimation_ratio < 4'h2 || adc_decimation_ratio > 4'hc)
        |=> left_decay_ms_ff <= agtc_pkg::LIM_4S0)
        else $error("Left decay exceeds 4 s for an unsupported ratio");

    // Read data is a register and moves only on a read strobe
    AST_RDATA_HOLDS: assert property (
        @(posedge clk) disable iff (!rst_n)
        !reg_rd_en |=> $stable(reg_rdata_ff))
        else $error("Read data changed without a read strobe");

    // A write to any other page-0 address must not disturb either register
    AST_STRAY_WRITE_IGNORED: assert property (
        @(posedge clk) disable iff (!rst_n)
        (reg_wr_en && reg_addr != agtc_pkg::LEFT_DECAY_ADDR
         && reg_addr != agtc_pkg::RIGHT_ATTACK_ADDR)
        |=> $stable(left_decay_cfg_ff) && $stable(right_attack_cfg_ff))
        else $error("Write to an unmapped address changed a register");
endmodule : agtc_time_cfg
`default_nettype wire

// ### bench/test_agc_time_constant_config.sv
// Self-checking bench for the AGC time constant register bank.
// Drives the page-0 register port, the legacy times and the decimation ratio itself; no partner model.
`timescale 1ns/100ps
`default_nettype none
module test_agc_time_constant_config;
    // Design ports
    logic clk;
    logic rst_n;
    logic [7:0] reg_addr;
    logic reg_wr_en;
    logic [7:0] reg_wdata;
    logic reg_rd_en;
    logic [7:0] reg_rdata_ff;
    logic [15:0] legacy_left_decay_ms;
    logic [15:0] legacy_right_attack_ms;
    logic [3:0] adc_decimation_ratio;
    logic [15:0] left_decay_ms_ff;
    logic [15:0] right_attack_ms_ff;
    logic left_decay_new_sel_ff;
    logic right_attack_new_sel_ff;
    // Bench state: what software has written
    int errors;
    int tests_run;
    int seed;
    logic [7:0] left_cfg;
    logic [7:0] right_cfg;
    logic [7:0] rdv;

    agtc_time_cfg dut_u (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en),
        .reg_wdata(reg_wdata), .reg_rd_en(reg_rd_en), .reg_rdata_ff(reg_rdata_ff),
        .legacy_left_decay_ms(legacy_left_decay_ms),
        .legacy_right_attack_ms(legacy_right_attack_ms),
        .adc_decimation_ratio(adc_decimation_ratio), .left_decay_ms_ff(left_decay_ms_ff),
        .right_attack_ms_ff(right_attack_ms_ff), .left_decay_new_sel_ff(left_decay_new_sel_ff),
        .right_attack_new_sel_ff(right_attack_new_sel_ff));

    // 125 MHz clock
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // Expected decay in ms: legacy or base times 2^mult, then capped by the doubled ratio
    function automatic logic [15:0] exp_decay(input logic [7:0] c, input logic [15:0] leg,
                                              input logic [3:0] r);
        logic [15:0] raw;
        logic [15:0] cap;
        case (c[6:5])
            2'h0: raw = 16'h0032;
            2'h1: raw = 16'h0096;
            2'h2: raw = 16'h00fa;
            default: raw = 16'h015e;
        endcase
        raw = c[7] ? (raw << c[4:2]) : leg;
        case (r)
            4'h3: cap = 16'h15e0;
            4'h4: cap = 16'h1f40;
            4'h5: cap = 16'h2580;
            4'h6, 4'h7: cap = 16'h2bc0;
            4'h8, 4'h9: cap = 16'h3e80;
            4'ha: cap = 16'h4b00;
            4'hb, 4'hc: cap = 16'h5780;
            default: cap = 16'h0fa0; // Unsupported codes take the tightest cap
        endcase
        return (raw > cap) ? cap : raw;
    endfunction : exp_decay

    // Expected attack in ms: legacy or base times 2^mult, never capped
    function automatic logic [15:0] exp_attack(input logic [7:0] c, input logic [15:0] leg);
        logic [15:0] raw;
        case (c[6:5])
            2'h0: raw = 16'h0007;
            2'h1: raw = 16'h0008;
            2'h2: raw = 16'h000a;
            default: raw = 16'h000b;
        endcase
        return c[7] ? (raw << c[4:2]) : leg;
    endfunction : exp_attack

    // Single compare point; four-state so an unknown never matches
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    // One-cycle write strobe; entered just after an edge, leaves an idle edge behind
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr = a;
        reg_wdata = d;
        reg_wr_en = 1'b1;
        @(posedge clk);
        #1;
        reg_wr_en = 1'b0;
        @(posedge clk);
        #1;
    endtask : wr

    // One-cycle read strobe; data is registered at the strobe edge
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        reg_addr = a;
        reg_rd_en = 1'b1;
        @(posedge clk);
        #1;
        reg_rd_en = 1'b0;
        d = reg_rdata_ff;
        @(posedge clk);
        #1;
    endtask : rd

    // Let the two-cycle write path settle, then compare outputs and readback
    task automatic settle_check;
        repeat (2) @(posedge clk);
        #1;
        check("left_decay_ms", left_decay_ms_ff,
              exp_decay(left_cfg, legacy_left_decay_ms, adc_decimation_ratio));
        check("right_attack_ms", right_attack_ms_ff,
              exp_attack(right_cfg, legacy_right_attack_ms));
        check("left_sel", {15'h0, left_decay_new_sel_ff}, {15'h0, left_cfg[7]});
        check("right_sel", {15'h0, right_attack_new_sel_ff}, {15'h0, right_cfg[7]});
        rd(8'h68, rdv);
        check("left_cfg", {8'h00, rdv}, {8'h00, left_cfg});
        rd(8'h69, rdv);
        check("right_cfg", {8'h00, rdv}, {8'h00, right_cfg});
    endtask : settle_check

    // Counts, then the verdict, then the end of the run
    task automatic summarize;
        $display("errors %0d tests_run %0d", errors, tests_run);
        if (errors == 0 && tests_run > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : summarize

    // Watchdog well beyond the expected thousand or so cycles
    initial begin
        #200000;
        errors++;
        summarize();
    end

    // Main sequence
    initial begin
        seed = 32'hb2f4198a;
        errors = 0;
        tests_run = 0;
        rst_n = 1'b0;
        {reg_addr, reg_wdata, reg_wr_en, reg_rd_en} = '0;
        legacy_left_decay_ms = 16'($random(seed));
        legacy_right_attack_ms = 16'($random(seed));
        adc_decimation_ratio = 4'h2;
        left_cfg = 8'h00;
        right_cfg = 8'h00;
        repeat (2) @(posedge clk);
        #1;
        rst_n = 1'b1;
        settle_check(); // Reset values select the legacy times
        // Every base and multiplier code, sweeping all ratio codes
        for (int i = 0; i < 32; i++) begin
            left_cfg = {1'b1, i[4:0], 2'h0}; // Reserved bits kept zero
            right_cfg = {1'b1, i[4:0], 2'h0};
            adc_decimation_ratio = i[3:0];
            wr(8'h68, left_cfg);
            wr(8'h69, right_cfg);
            settle_check();
        end
        // Corners: left writes alone, so the quiet-cycle checks see them
        adc_decimation_ratio = 4'h2;
        left_cfg = 8'h80; // 50 ms x1, read back in the cycle after the write
        reg_addr = 8'h68;
        reg_wdata = left_cfg;
        reg_wr_en = 1'b1;
        @(posedge clk);
        #1;
        reg_wr_en = 1'b0;
        reg_rd_en = 1'b1;
        @(posedge clk);
        #1;
        reg_rd_en = 1'b0;
        check("left_wr_rd", {8'h00, reg_rdata_ff}, {8'h00, left_cfg});
        settle_check();
        left_cfg = 8'hfc; // 350 ms x128 against the 22.4 s and then the 8 s ceiling
        adc_decimation_ratio = 4'hc;
        wr(8'h68, left_cfg);
        settle_check();
        adc_decimation_ratio = 4'h4;
        settle_check();
        // Random configuration, legacy times and ratios
        for (int i = 0; i < 60; i++) begin
            left_cfg = 8'($random(seed)) & 8'hfc;
            right_cfg = 8'($random(seed)) & 8'hfc;
            legacy_left_decay_ms = 16'($random(seed));
            legacy_right_attack_ms = 16'($random(seed));
            adc_decimation_ratio = 4'($random(seed));
            wr(8'h68, left_cfg);
            wr(8'h69, right_cfg);
            settle_check();
        end
        // Unmapped address: write dropped, read returns zero
        wr(8'h6a, 8'hfc);
        rd(8'h6a, rdv);
        check("unmapped_rd", {8'h00, rdv}, 16'h0000);
        settle_check();
        // Reset in mid-run clears outputs and both registers
        rst_n = 1'b0;
        #2;
        check("rst_left", left_decay_ms_ff, 16'h0000);
        check("rst_right", right_attack_ms_ff, 16'h0000);
        @(posedge clk);
        #1;
        rst_n = 1'b1;
        left_cfg = 8'h00;
        right_cfg = 8'h00;
        settle_check();
        summarize();
    end
endmodule : test_agc_time_constant_config
`default_nettype wire
